// file: src/pmc_defines.svh
/*
  Constants for the power-mode and clock control block: register offsets,
  field positions, reset values and timing counts.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// Register word indices (AXI4-Lite byte address is four times the index)
`define PMC_IDX_PWR_CTRL 8'h87
`define PMC_IDX_CLK_SPEED 8'h8e
`define PMC_IDX_EXT_FLAGS 8'h91
`define PMC_IDX_PWR_MGMT 8'h92
`define PMC_ADDR_W 10

// Power control fields
`define PMC_POWER_CONTROL_IDLE 0
`define PMC_POWER_CONTROL_STOP 1
// Clock speed control fields
`define PMC_CK_T0 3
`define PMC_CK_T1 4
`define PMC_CK_T2 5
// Extended flags fields
`define PMC_EX_REF 0
`define PMC_EX_RING 1
`define PMC_EX_RACT 2
// Power management fields
`define PMC_PM_STROBE 2

// Reset values
`define PMC_RST_BYTE 8'h00

// Timing
`define PMC_RING_XTAL_CLKS 17'h10000
`define PMC_XTAL_STABLE_CLKS 17'h10000
`define PMC_DIV4 4'h4
`define PMC_DIV12 4'hc

// Bus responses
`define PMC_RESP_OKAY 2'b00
`define PMC_RESP_SLVERR 2'b10

`endif

// file: src/pmc_pkg.sv
/*
  Types for the power-mode and clock control block.
  Assumes pmc_defines.svh is on the include path.
*/
`default_nettype none
`include "pmc_defines.svh"
package pmc_pkg;
  // Power state of the core
  typedef enum logic [2:0] {
    PMC_RUN = 3'b000,
    PMC_IDLE = 3'b001,
    PMC_STOP = 3'b010,
    PMC_WAKE_XTAL = 3'b011,
    PMC_RING_RUN = 3'b100
  } pmc_state_t;

  // Wake sources seen by the block
  typedef struct packed {
    logic extIrq;
    logic rtcAlarm;
    logic powerFailIrq;
    logic powerFailRst;
    logic anyIrq;
  } pmc_wake_t;

  // Clock and gating outputs
  typedef struct packed {
    logic coreHalt;
    logic clocksGated;
    logic refPowered;
    logic ringClock;
    logic strobe;
  } pmc_ctrl_t;
endpackage
`default_nettype wire

// file: src/pmc_prescaler.sv
/*
  One timer prescaler: pulses a tick every 4 or 12 input clocks.
  Assumes enable is low while clocks are gated in stop.
*/
`default_nettype none
`include "pmc_defines.svh"
module pmc_prescaler
  import pmc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic enable,
  input wire logic fast,
  // Tick
  output logic tick
);
  logic [3:0] countReg; // Clocks within one timer cycle
  logic [3:0] limit;    // Selected divide ratio

  // Divide ratio: one selects 4 clocks, zero selects 12
  assign limit = fast ? `PMC_DIV4 : `PMC_DIV12;

  // Counter and tick, stopped while clocks are gated
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      countReg <= 4'h0;
      tick <= 1'b0;
    end else if (!enable) begin
      tick <= 1'b0;
    end else if (countReg >= limit - 4'h1) begin
      countReg <= 4'h0;
      tick <= 1'b1;
    end else begin
      countReg <= countReg + 4'h1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: src/pmc_top.sv
/*
  Power-mode and clock control with an AXI4-Lite register slave.
  Holds idle and stop entry, stop wake-up, reference-in-stop, ring wake with
  automatic crystal return, strobe suppression and timer prescale select.
  Assumes wake sources are synchronous levels; the clock here models the
  crystal time base, so the ring count and stabilisation count use it.
*/
// Decided for this implementation: the AXI4-Lite slave port.
// Operation
// - Power control bit 0 enters idle
// - Idle halts core, clocks and timers run
// - Idle ends on any interrupt or reset
// - Power control bit 1 enters stop, clocks gated
// - Stop ends on external interrupt or reset
// - Real-time clock alarm also ends stop
// - Reference select keeps reference powered in stop
// - Powered reference lets power-fail events end stop
// - Reference select ignored outside stop
// - Default stop exit uses restarted crystal
// - Ring select resumes from stop on ring
// - Ring run returns to crystal after 65536
// - Ring flag reads one on ring clock
// - Strobe suppress keeps strobe static on-chip
// - Strobe suppress resets zero, strobe every cycle
// - Timers reset to twelve clocks per cycle
// - Speed bit one gives four, zero twelve
// - Each timer has its own speed bit
// - Ring flag reads zero on crystal
`default_nettype none
`include "pmc_defines.svh"
module pmc_top
  import pmc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`PMC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [`PMC_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Wake sources and core cycle marks
  input wire pmc_wake_t wake,
  input wire logic instrCycle,
  input wire logic extDataMove,
  // Control outputs
  output pmc_ctrl_t ctrl,
  output logic [2:0] timerTick
);
  pmc_state_t stateReg;          // Power state
  logic [7:0] pwrCtrlReg;        // Power control
  logic [7:0] clkSpeedReg;       // Clock speed control
  logic [1:0] extCtlReg;         // Reference and ring select bits
  logic [7:0] pwrMgmtReg;        // Power management
  logic [16:0] countReg;         // Ring or stabilisation counter
  logic wakeStop;                // Stop exit condition
  logic awHeld, wHeld;           // Write channels captured
  logic [`PMC_ADDR_W-1:0] awAddrReg;
  logic [31:0] wDataReg;
  logic [3:0] wStrbReg;
  logic wrFire;                  // Both write halves present
  logic [7:0] wrIdx;             // Written register index
  logic wrHit;                   // Written address mapped
  logic wrEn;                    // Mapped write with lane 0 enabled
  logic [7:0] rdIdx;
  logic [7:0] rdByte;
  logic rdHit;
  logic ringActive;
  logic [2:0] fastSel;

  // Ring flag is a pure function of state so it can never disagree
  assign ringActive = (stateReg == PMC_RING_RUN);

  // Stop wake: external, alarm, or power-fail only with reference kept on
  assign wakeStop = wake.extIrq || wake.rtcAlarm ||
    (extCtlReg[`PMC_EX_REF] && (wake.powerFailIrq || wake.powerFailRst));

  // Write side: addresses are register indices, byte address is four times
  assign wrFire = awHeld && wHeld && !s_axi_bvalid;
  assign wrIdx = awAddrReg[9:2];
  assign wrHit = (awAddrReg[1:0] == 2'b00) && (wrIdx == `PMC_IDX_PWR_CTRL ||
    wrIdx == `PMC_IDX_CLK_SPEED || wrIdx == `PMC_IDX_EXT_FLAGS || wrIdx == `PMC_IDX_PWR_MGMT);
  // Refused writes (unmapped, misaligned, lane 0 off) must not land anywhere
  assign wrEn = wrFire && wrHit && wStrbReg[0];

  // Capture write address; accepted at most once until response
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      awAddrReg <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      if (s_axi_awvalid && !awHeld && !s_axi_awready) begin
        awHeld <= 1'b1;
        awAddrReg <= s_axi_awaddr;
        s_axi_awready <= 1'b1;
      end else if (wrFire) begin
        awHeld <= 1'b0;
      end
    end
  end

  // Capture write data independently, so either order works
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wHeld <= 1'b0;
      wDataReg <= '0;
      wStrbReg <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= 1'b0;
      if (s_axi_wvalid && !wHeld && !s_axi_wready) begin
        wHeld <= 1'b1;
        wDataReg <= s_axi_wdata;
        wStrbReg <= s_axi_wstrb;
        s_axi_wready <= 1'b1;
      end else if (wrFire) begin
        wHeld <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses get a slave error
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PMC_RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrHit ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Plain registers; only byte lane 0 carries data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkSpeedReg <= `PMC_RST_BYTE;
      extCtlReg <= 2'b00;
      pwrMgmtReg <= `PMC_RST_BYTE;
    end else if (wrEn) begin
      if (wrIdx == `PMC_IDX_CLK_SPEED) begin
        clkSpeedReg <= wDataReg[7:0];
      end
      if (wrIdx == `PMC_IDX_EXT_FLAGS) begin
        // Ring flag bit is read-only and not stored
        extCtlReg <= wDataReg[1:0];
      end
      if (wrIdx == `PMC_IDX_PWR_MGMT) begin
        pwrMgmtReg <= wDataReg[7:0];
      end
    end
  end

  // Power control: mode bits self-clear on exit; exit wins over a write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwrCtrlReg <= `PMC_RST_BYTE;
    end else if (stateReg == PMC_IDLE && wake.anyIrq) begin
      pwrCtrlReg[`PMC_POWER_CONTROL_IDLE] <= 1'b0;
    end else if (stateReg == PMC_STOP && wakeStop) begin
      pwrCtrlReg[`PMC_POWER_CONTROL_STOP] <= 1'b0;
    end else if (wrEn && wrIdx == `PMC_IDX_PWR_CTRL) begin
      pwrCtrlReg <= wDataReg[7:0];
    end
  end

  // Power state machine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= PMC_RUN;
      countReg <= '0;
    end else begin
      case (stateReg)
        PMC_RUN, PMC_RING_RUN: begin
          if (stateReg == PMC_RING_RUN) begin
            if (countReg == `PMC_RING_XTAL_CLKS - 17'h1) begin
              stateReg <= PMC_RUN;
            end else begin
              countReg <= countReg + 17'h1;
            end
          end
          // Stop takes precedence when both are requested
          if (pwrCtrlReg[`PMC_POWER_CONTROL_STOP]) begin
            stateReg <= PMC_STOP;
          end else if (pwrCtrlReg[`PMC_POWER_CONTROL_IDLE]) begin
            stateReg <= PMC_IDLE;
          end
        end
        PMC_IDLE: begin
          if (wake.anyIrq) begin
            stateReg <= PMC_RUN;
          end
        end
        PMC_STOP: begin
          countReg <= '0;
          if (wakeStop) begin
            stateReg <= extCtlReg[`PMC_EX_RING] ? PMC_RING_RUN : PMC_WAKE_XTAL;
          end
        end
        PMC_WAKE_XTAL: begin
          if (countReg == `PMC_XTAL_STABLE_CLKS - 17'h1) begin
            stateReg <= PMC_RUN;
            countReg <= '0;
          end else begin
            countReg <= countReg + 17'h1;
          end
        end
        default: begin
          stateReg <= PMC_RUN;
        end
      endcase
    end
  end

  // Control outputs from flip-flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '0;
    end else begin
      ctrl.coreHalt <= (stateReg != PMC_RUN && stateReg != PMC_RING_RUN);
      ctrl.clocksGated <= (stateReg == PMC_STOP);
      // Reference is always on except in stop without the select bit
      ctrl.refPowered <= (stateReg != PMC_STOP) || extCtlReg[`PMC_EX_REF];
      ctrl.ringClock <= ringActive;
      // Suppressed strobe still pulses for off-chip data moves
      ctrl.strobe <= instrCycle && (stateReg != PMC_STOP) &&
        (!pwrMgmtReg[`PMC_PM_STROBE] || extDataMove);
    end
  end

  // Timer prescalers: bits 3,4,5 select timers 0,1,2
  assign fastSel = {clkSpeedReg[`PMC_CK_T2], clkSpeedReg[`PMC_CK_T1], clkSpeedReg[`PMC_CK_T0]};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : gTimer
      // Timers keep running in idle, stop only when clocks are gated
      pmc_prescaler uPre (
        .clk(clk),
        .rst_n(rst_n),
        .enable(stateReg != PMC_STOP),
        .fast(fastSel[gi]),
        .tick(timerTick[gi])
      );
    end
  endgenerate

  // Read decode
  assign rdIdx = s_axi_araddr[9:2];
  always_comb begin
    rdHit = (s_axi_araddr[1:0] == 2'b00);
    rdByte = 8'h00;
    case (rdIdx)
      `PMC_IDX_PWR_CTRL: rdByte = pwrCtrlReg;
      `PMC_IDX_CLK_SPEED: rdByte = clkSpeedReg;
      `PMC_IDX_EXT_FLAGS: rdByte = {5'h00, ringActive, extCtlReg};
      `PMC_IDX_PWR_MGMT: rdByte = pwrMgmtReg;
      default: rdHit = 1'b0;
    endcase
  end

  // Read channel: one cycle to answer, held until taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `PMC_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else if (s_axi_arvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rdByte};
        s_axi_rresp <= rdHit ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
      end
    end
  end

  // Assertions
  AST_STOP_GATES: assert property (@(posedge clk) disable iff (!rst_n)
    stateReg == PMC_STOP |=> ctrl.clocksGated && ctrl.coreHalt)
    else $error("stop did not gate clocks");
  AST_STOP_NO_TIMER_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
    (stateReg == PMC_STOP && !wake.extIrq && !wake.rtcAlarm && !extCtlReg[`PMC_EX_REF]) |=> stateReg == PMC_STOP)
    else $error("stop left without valid source");
  AST_RTC_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
    (stateReg == PMC_STOP && wake.rtcAlarm) |=> stateReg inside {PMC_RING_RUN, PMC_WAKE_XTAL})
    else $error("alarm did not end stop");
  AST_PF_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
    (stateReg == PMC_STOP && extCtlReg[`PMC_EX_REF] && wake.powerFailIrq) |=> stateReg != PMC_STOP)
    else $error("power fail did not end stop");
  AST_REF_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    (stateReg == PMC_STOP && !extCtlReg[`PMC_EX_REF]) |=> !ctrl.refPowered)
    else $error("reference on in stop");
  AST_IDLE_EXIT: assert property (@(posedge clk) disable iff (!rst_n)
    (stateReg == PMC_IDLE && wake.anyIrq) |=> stateReg == PMC_RUN ##1 !ctrl.coreHalt)
    else $error("idle not left on interrupt");
  AST_RING_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl.ringClock == $past(stateReg == PMC_RING_RUN))
    else $error("ring flag mismatch");
  AST_RING_EXIT: assert property (@(posedge clk) disable iff (!rst_n)
    (stateReg == PMC_STOP && wakeStop && extCtlReg[`PMC_EX_RING]) |=> ringActive ##2 !ctrl.coreHalt)
    else $error("ring wake not immediate");
  AST_STROBE_SUPP: assert property (@(posedge clk) disable iff (!rst_n)
    (pwrMgmtReg[`PMC_PM_STROBE] && !extDataMove) |=> !ctrl.strobe)
    else $error("strobe pulsed while suppressed");
  AST_XTAL_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (stateReg == PMC_STOP && wakeStop && !extCtlReg[`PMC_EX_RING]) |=> stateReg == PMC_WAKE_XTAL [*8])
    else $error("crystal exit did not wait");
  AST_REF_ON_OUTSIDE_STOP: assert property (@(posedge clk) disable iff (!rst_n)
    stateReg != PMC_STOP |=> ctrl.refPowered)
    else $error("reference off outside stop");
  AST_RING_RETURN: assert property (@(posedge clk) disable iff (!rst_n)
    (stateReg == PMC_RING_RUN && countReg == `PMC_RING_XTAL_CLKS - 17'h1) |=> stateReg != PMC_RING_RUN)
    else $error("ring run did not return to crystal");
  AST_BAD_WRITE_IGNORED: assert property (@(posedge clk) disable iff (!rst_n)
    (wrFire && !wrHit && stateReg == PMC_RUN) |=> $stable(pwrCtrlReg) && $stable(clkSpeedReg) &&
      $stable(pwrMgmtReg) && $stable(extCtlReg))
    else $error("refused write changed a register");
  COV_IDLE: cover property (@(posedge clk) disable iff (!rst_n) stateReg == PMC_IDLE ##1 stateReg == PMC_RUN);
  COV_RING: cover property (@(posedge clk) disable iff (!rst_n) stateReg == PMC_STOP ##1 stateReg == PMC_RING_RUN);
  COV_XTAL: cover property (@(posedge clk) disable iff (!rst_n) stateReg == PMC_STOP ##1 stateReg == PMC_WAKE_XTAL);
endmodule
`default_nettype wire

// file: test/testbench.sv
/*
  Self-checking bench for the power-mode and clock control block.
  Drives the register bus, wake sources and core cycle marks directly.
  Assumes the design counts, the package types and the register index map.
*/
`default_nettype none
`include "pmc_defines.svh"
module testbench
  import pmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // Bit positions inside ctrl
  localparam int HALT = 4;
  localparam int GATE = 3;
  localparam int REF = 2;
  localparam int RING = 1;
  localparam int STRB = 0;
  // Byte addresses: printed offsets are word indices
  localparam logic [9:0] A_PWR = {`PMC_IDX_PWR_CTRL, 2'b00};
  localparam logic [9:0] A_CK = {`PMC_IDX_CLK_SPEED, 2'b00};
  localparam logic [9:0] A_EXT = {`PMC_IDX_EXT_FLAGS, 2'b00};
  localparam logic [9:0] A_PM = {`PMC_IDX_PWR_MGMT, 2'b00};
  // Clock, reset and bus
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  // Wake sources and outputs
  pmc_wake_t wake = '0;
  logic instrCycle = 1'b0;
  logic extDataMove = 1'b0;
  pmc_ctrl_t ctrl;
  logic [2:0] timerTick;
  // Bench state
  int mismatches = 0;
  int n_checks = 0;
  int ringCycles = 0; // Length of the last ring-clocked run
  logic [31:0] seed = 32'h8526;
  logic [1:0] lastResp; // Response of the last bus access
  logic [31:0] lastData;
  int mdlExt = 0; // Model of the writable extended flag bits

  always #5 clk = ~clk;

  pmc_top pmc_top_inst (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .wake(wake), .instrCycle(instrCycle), .extDataMove(extDataMove),
    .ctrl(ctrl), .timerTick(timerTick)
  );

  // Ring run length, measured independently of the main sequence
  always @(posedge clk) begin
    if (ctrl[RING] === 1'b1) begin
      ringCycles <= ringCycles + 1;
    end
  end

  // Fixed-seed xorshift source of random register values
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Address and data offered together, each released when taken
  // Waits for the response however long it takes; only the watchdog ends a hang
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    lastResp = s_axi_bresp;
  endtask

  // One extra edge at the end so arvalid is never driven twice in a step
  task automatic rd(input logic [9:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    lastResp = s_axi_rresp;
    lastData = s_axi_rdata;
    @(posedge clk);
  endtask

  task automatic rd_check(input logic [9:0] a, input logic [31:0] exp);
    rd(a);
    check(lastData, exp);
  endtask

  // Bounded wait for one ctrl bit, then compare it
  task automatic wait_bit(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (ctrl[b] !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    check(ctrl[b], v);
  endtask

  // Cycles between two successive ticks of one timer
  task automatic tick_gap(input int t, output int g);
    int n;
    n = 0;
    g = 0;
    while (timerTick[t] !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    g = 1;
    while (timerTick[t] !== 1'b1 && g < 40) begin
      @(posedge clk);
      g++;
    end
  endtask

  // Strobe pulses seen over a short run of instruction cycles
  task automatic strobe_count(output int c);
    c = 0;
    instrCycle <= 1'b1;
    repeat (16) begin
      @(posedge clk);
      if (ctrl[STRB] === 1'b1) c++;
    end
    instrCycle <= 1'b0;
  endtask

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  // Enter stop with the given extended flag setting
  task automatic enter_stop(input logic [7:0] ext);
    wr(A_EXT, ext);
    mdlExt = int'(ext & 8'h03);
    wr(A_PWR, 8'h02);
    wait_bit(GATE, 1'b1, 5);
  endtask

  // Hang guard at 90k cycles, above the expected run of about 67k cycles
  initial begin
    #900000;
    mismatches++;
    close_out();
  end

  initial begin
    int g, c;
    logic [7:0] v;
    do_reset();
    check(ctrl[REF], 1'b1);
    check(ctrl[HALT], 1'b0);
    rd_check(A_PWR, 32'h0);
    rd_check(A_CK, 32'h0);
    rd_check(A_EXT, 32'h0);
    rd_check(A_PM, 32'h0);
    rd(10'h000);
    check(lastResp, `PMC_RESP_SLVERR);
    // Misaligned and lane-less writes are refused and must leave no trace
    wr(A_PWR + 10'h001, 8'h01);
    check(lastResp, `PMC_RESP_SLVERR);
    s_axi_wstrb <= 4'he;
    wr(A_PM, 8'h04);
    s_axi_wstrb <= 4'hf;
    repeat (3) @(posedge clk);
    check(ctrl[HALT], 1'b0);
    rd_check(A_PWR, 32'h0);
    rd_check(A_PM, 32'h0);
    wr(A_EXT, 8'h04);
    rd_check(A_EXT, 32'h0);
    tick_gap(0, g);
    tick_gap(0, g);
    check(g, 12);
    // Timer speed: two fixed patterns then random ones
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      v = (i == 0) ? 8'h28 : (i == 1) ? 8'h10 : (seed[7:0] & 8'h38);
      wr(A_CK, v);
      rd_check(A_CK, {24'h0, v});
      for (int t = 0; t < 3; t++) begin
        tick_gap(t, g);
        tick_gap(t, g);
        check(g, v[3 + t] ? 4 : 12);
      end
    end
    // Strobe suppression
    strobe_count(c);
    check(c > 0, 1);
    wr(A_PM, 8'h04);
    strobe_count(c);
    check(c, 0);
    extDataMove <= 1'b1;
    @(posedge clk);
    strobe_count(c);
    check(c > 0, 1);
    extDataMove <= 1'b0;
    wr(A_PM, 8'h00);
    // Idle: core halted, clocks and timers keep running
    wr(A_PWR, 8'h01);
    wait_bit(HALT, 1'b1, 5);
    check(ctrl[GATE], 1'b0);
    check(ctrl[REF], 1'b1);
    tick_gap(0, g);
    check(g < 40, 1);
    wake.anyIrq <= 1'b1;
    wait_bit(HALT, 1'b0, 5);
    wake.anyIrq <= 1'b0;
    rd_check(A_PWR, 32'h0);
    // Stop, reference off: internal and power-fail sources do not wake
    enter_stop(8'h00);
    check(ctrl[REF], 1'b0);
    c = 0;
    wake.anyIrq <= 1'b1;
    wake.powerFailIrq <= 1'b1;
    repeat (30) begin
      @(posedge clk);
      if (timerTick !== 3'b000) c++;
    end
    check(c, 0);
    check(ctrl[GATE], 1'b1);
    check(ctrl[HALT], 1'b1);
    wake.anyIrq <= 1'b0;
    wake.powerFailIrq <= 1'b0;
    wake.rtcAlarm <= 1'b1;
    repeat (2) @(posedge clk);
    wake.rtcAlarm <= 1'b0;
    rd_check(A_PWR, 32'h0);
    repeat (100) @(posedge clk);
    check(ctrl[RING], 1'b0);
    check(ctrl[HALT], 1'b1);
    do_reset();
    check(ctrl[HALT], 1'b0);
    // Stop, reference kept on: power-fail interrupt wakes
    enter_stop(8'h01);
    check(ctrl[REF], 1'b1);
    wake.powerFailIrq <= 1'b1;
    repeat (2) @(posedge clk);
    wake.powerFailIrq <= 1'b0;
    rd_check(A_PWR, 32'h0);
    do_reset();
    // Stop with ring wake: power-fail reset wakes onto the ring; its run length is checked against 65536 cycles
    enter_stop(8'h03);
    ringCycles = 0;
    wake.powerFailRst <= 1'b1;
    wait_bit(RING, 1'b1, 5);
    wake.powerFailRst <= 1'b0;
    check(ctrl[HALT], 1'b0);
    rd_check(A_EXT, 32'(mdlExt) | 32'h4);
    wait_bit(RING, 1'b0, 70000);
    check(ringCycles, 32'd65536);
    check(ctrl[HALT], 1'b0);
    rd_check(A_EXT, 32'(mdlExt));
    // Ring wake from an external interrupt, cut short by reset
    enter_stop(8'h02);
    check(ctrl[REF], 1'b0);
    wake.extIrq <= 1'b1;
    wait_bit(RING, 1'b1, 5);
    wake.extIrq <= 1'b0;
    do_reset();
    check(ctrl[RING], 1'b0);
    rd_check(A_EXT, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
